// file: logic/ast_pkg.sv
package ast_pkg;

   // register byte offsets, one aligned word each
   localparam int unsigned   ADDR_W         = 8;
   localparam logic [7:0]    OFS_CTRL_ZERO  = 8'h00;
   localparam logic [7:0]    OFS_CTRL_ONE   = 8'h04;
   localparam logic [7:0]    OFS_RESULT     = 8'h08;
   localparam logic [7:0]    OFS_IRQ_STATUS = 8'h0C;
   localparam logic [7:0]    OFS_IRQ_MASK   = 8'h10;
   localparam logic [7:0]    OFS_STATE      = 8'h14;

   // field positions
   localparam int unsigned   ON_BIT         = 0;
   localparam int unsigned   GO_BIT         = 1;
   localparam int unsigned   SEL_LSB        = 4;
   localparam int unsigned   SEL_W          = 3;
   localparam int unsigned   DONE_BIT       = 0;
   localparam int unsigned   PD_BIT         = 0;
   localparam int unsigned   BUSY_BIT       = 1;
   localparam int unsigned   RESULT_W       = 10;
   localparam int unsigned   BIT_CNT_W      = 4;
   localparam int unsigned   DIV_CNT_W      = 7;

   // reset values
   localparam logic [2:0]    SEL_RESET      = 3'h0;
   localparam logic [31:0]   WORD_ZERO      = 32'h0000_0000;
   localparam logic [9:0]    RESULT_RESET   = 10'h000;
   localparam logic [9:0]    RESULT_MSB_ONE = 10'h200;

   // conversion clock codes
   localparam logic [2:0]    SEL_DIV2       = 3'h0;
   localparam logic [2:0]    SEL_DIV8       = 3'h1;
   localparam logic [2:0]    SEL_DIV32      = 3'h2;
   localparam logic [2:0]    SEL_DIV4       = 3'h4;
   localparam logic [2:0]    SEL_DIV16      = 3'h5;
   localparam logic [2:0]    SEL_DIV64      = 3'h6;
   localparam logic [1:0]    SEL_RC_LOW     = 2'h3;

   // timing: instruction cycle is four system clocks
   localparam int unsigned   CLK_PERIOD_NS  = 100;
   localparam int unsigned   INSTR_NS       = 400;
   localparam logic [2:0]    INSTR_CYCLES   = 3'((INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0]    RECOVER_TADS   = 2'h2;
   localparam logic [3:0]    SAR_LAST_BIT   = 4'h0;
   localparam logic [3:0]    SAR_FIRST_BIT  = 4'h9;

   // conversion sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONVERT, ST_RECOVER} ast_state_t;

   // true when the code picks the dedicated rc clock
   function automatic logic ast_is_rc(input logic [2:0] sel);
      return sel[1:0] == SEL_RC_LOW;
   endfunction

   // system clock division ratio for a code
   function automatic logic [6:0] ast_div_ratio(input logic [2:0] sel);
      logic [6:0] r;
      r = 7'h02;
      unique case (sel)
         SEL_DIV2:  r = 7'h02;
         SEL_DIV8:  r = 7'h08;
         SEL_DIV32: r = 7'h20;
         SEL_DIV4:  r = 7'h04;
         SEL_DIV16: r = 7'h10;
         SEL_DIV64: r = 7'h40;
         default:   r = 7'h02;
      endcase
      return r;
   endfunction

endpackage

// file: logic/ast_tad_gen.sv
`timescale 1ns/1ps
// one pulse per conversion clock period, from the divider or the rc clock
module ast_tad_gen
   import ast_pkg::*;
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [2:0]   sel,
   input  wire logic         run,
   input  wire logic         rc_clk_in,
   output      logic         tad_tick
);

   logic [6:0] cnt_ff;     // divider count
   logic [6:0] nxt_cnt;
   logic       rc_q_ff;    // previous rc level
   logic       div_hit;    // divider wraps
   logic       rc_rise;    // rising rc edge

   assign div_hit  = (cnt_ff == (ast_div_ratio(sel) - 7'h01));
   assign rc_rise  = rc_clk_in & ~rc_q_ff;
   assign nxt_cnt  = (!run || div_hit) ? 7'h00 : (cnt_ff + 7'h01);
   assign tad_tick = run & (ast_is_rc(sel) ? rc_rise : div_hit);

   // divider counter and rc edge register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff  <= 7'h00;
         rc_q_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         rc_q_ff <= rc_clk_in;
      end
   end

endmodule

// file: logic/ast_adc_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - keep converting in sleep only on rc clock
// - rc clock delays start one instruction cycle
// - done wakes sleeping device when interrupt enabled
// - rc sleep, interrupt off: power down after done
// - sleep on divided clock aborts and powers down
// - special event sets go, clears timer one
// - clock select field bits six to four
// - other clock register bits read zero
// - completion clears go, sets done, loads result
// - software abort keeps result, two period recovery
// - go ignored unless converter already on
module ast_adc_ctrl
   import ast_pkg::*;
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output      logic         hreadyout,
   output      logic         hresp,
   output      logic [31:0]  hrdata,
   input  wire logic         sleep_in,
   input  wire logic         special_event_in,
   input  wire logic         rc_clk_in,
   input  wire logic         cmp_in,
   output      logic [9:0]   sar_trial,
   output      logic         sample_en,
   output      logic         analog_power,
   output      logic         timer_one_clear,
   output      logic         wake_out,
   output      logic         irq
);

   // bus slave state
   logic        rd_pend_ff;     // read data phase pending
   logic        rd_ready_ff;    // read data loaded
   logic        wr_pend_ff;     // write data phase pending
   logic [7:0]  addr_ff;        // captured address
   logic [31:0] hrdata_ff;      // read data register
   logic        addr_phase;     // address phase taken
   logic        wr_en;          // write strobe
   logic [31:0] rd_mux;         // read selection

   // control and status
   logic        on_ff;          // converter_on
   logic        go_ff;          // convert_go_flag
   logic [2:0]  sel_ff;         // conv_clock_select
   logic [9:0]  result_ff;      // result_register_pair
   logic        done_ff;        // conversion_done_flag
   logic        mask_ff;        // converter interrupt enable
   logic        pd_ff;          // converter powered down
   logic        nxt_go;
   logic        nxt_done;
   logic        nxt_pd;

   // sequencer
   ast_state_t  state_ff;
   ast_state_t  nxt_state;
   logic [2:0]  delay_ff;       // instruction cycle wait
   logic [2:0]  nxt_delay;
   logic [3:0]  bit_ff;         // bit under trial
   logic [9:0]  sar_ff;         // trial word
   logic [9:0]  nxt_sar;
   logic [1:0]  rec_ff;         // recovery periods left
   logic [1:0]  nxt_rec;
   logic        tad_tick;
   logic        busy;
   logic        rc_sel;

   // event decode
   logic        sleep_q_ff;     // previous sleep level
   logic        sleep_entry;
   logic        trig_q_ff;      // previous trigger level
   logic        trig_strobe;
   logic        trig_clr_ff;    // timer one clear pulse
   logic        sw_go_set;
   logic        sw_go_clr;
   logic        start_req;
   logic        complete;
   logic        abort_sw;
   logic        abort_sleep;
   logic        bit_keep;

   // bus decode
   assign addr_phase = hsel & htrans[1] & hready;
   assign wr_en      = wr_pend_ff;
   assign hreadyout  = ~rd_pend_ff | rd_ready_ff;
   assign hresp      = 1'b0;
   assign hrdata     = hrdata_ff;

   // read mux, unmapped words read zero
   assign rd_mux =
      (addr_ff == OFS_CTRL_ZERO)  ? {30'h0000_0000, go_ff, on_ff} :
      // only bits six to four are driven
      (addr_ff == OFS_CTRL_ONE)   ? {25'h000_0000, sel_ff, 4'h0} :
      (addr_ff == OFS_RESULT)     ? {22'h00_0000, result_ff} :
      (addr_ff == OFS_IRQ_STATUS) ? {31'h0000_0000, done_ff} :
      (addr_ff == OFS_IRQ_MASK)   ? {31'h0000_0000, mask_ff} :
      (addr_ff == OFS_STATE)      ? {30'h0000_0000, busy, pd_ff} : WORD_ZERO;

   // address capture, one wait state on reads
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_ff  <= 1'b0;
         wr_pend_ff  <= 1'b0;
         rd_ready_ff <= 1'b0;
         addr_ff     <= 8'h00;
      end else if (hreadyout) begin
         rd_pend_ff  <= addr_phase & ~hwrite;
         wr_pend_ff  <= addr_phase & hwrite;
         rd_ready_ff <= 1'b0;
         addr_ff     <= addr_phase ? haddr[7:0] : addr_ff;
      end else begin
         rd_ready_ff <= 1'b1;
      end
   end

   // read data register loads in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= WORD_ZERO;
      end else if (rd_pend_ff && !rd_ready_ff) begin
         hrdata_ff <= rd_mux;
      end
   end

   // software and trigger events
   assign sleep_entry = sleep_in & ~sleep_q_ff;
   // level edge gives a single cycle strobe
   assign trig_strobe = special_event_in & ~trig_q_ff;
   assign sw_go_set   = wr_en & (addr_ff == OFS_CTRL_ZERO) & hwdata[GO_BIT];
   assign sw_go_clr   = wr_en & (addr_ff == OFS_CTRL_ZERO) & ~hwdata[GO_BIT];
   assign rc_sel      = ast_is_rc(sel_ff);
   assign busy        = (state_ff == ST_DELAY) | (state_ff == ST_CONVERT);
   // request needs converter_on set beforehand
   // no start in the cycle that a divided clock sleep powers the converter down
   assign start_req   = (state_ff == ST_IDLE) & on_ff & ~pd_ff & (sw_go_set | trig_strobe)
                        & ~(sleep_entry & ~rc_sel);
   assign bit_keep    = cmp_in;
   // last bit decided on a period tick
   assign complete    = (state_ff == ST_CONVERT) & tad_tick & (bit_ff == SAR_LAST_BIT)
                        & ~abort_sleep & ~abort_sw;
   assign abort_sw    = busy & sw_go_clr & ~trig_strobe & ~abort_sleep;
   // sleep on a divided clock aborts
   assign abort_sleep = busy & sleep_entry & ~rc_sel;

   // conversion clock period source
   ast_tad_gen u_tad (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .sel       (sel_ff),
      .run       (on_ff & ~pd_ff),
      .rc_clk_in (rc_clk_in),
      .tad_tick  (tad_tick)
   );

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_delay = delay_ff;
      nxt_rec   = rec_ff;
      nxt_sar   = sar_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start_req) begin
               // rc clock waits one instruction cycle first
               nxt_state = rc_sel ? ST_DELAY : ST_CONVERT;
               nxt_delay = INSTR_CYCLES - 3'h1;
               nxt_sar   = RESULT_MSB_ONE;
            end
         end
         ST_DELAY: begin
            if (delay_ff == 3'h0) begin
               nxt_state = ST_CONVERT;
            end else begin
               nxt_delay = delay_ff - 3'h1;
            end
         end
         ST_CONVERT: begin
            if (tad_tick) begin
               // keep or drop the trial bit, then try the next one
               nxt_sar = bit_keep ? sar_ff : (sar_ff & ~(RESULT_MSB_ONE >> (SAR_FIRST_BIT - bit_ff)));
               if (bit_ff != SAR_LAST_BIT) begin
                  nxt_sar = nxt_sar | (RESULT_MSB_ONE >> (SAR_FIRST_BIT - bit_ff + 4'h1));
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_RECOVER: begin
            if (tad_tick) begin
               nxt_rec   = rec_ff - 2'h1;
               nxt_state = (rec_ff == 2'h1) ? ST_IDLE : ST_RECOVER;
            end
         end
      endcase
      if (abort_sw) begin
         nxt_state = ST_RECOVER;
         nxt_rec   = RECOVER_TADS;
      end
      if (abort_sleep || pd_ff) begin
         nxt_state = ST_IDLE;
      end
   end

   // sequencer registers, reset aborts any conversion
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_IDLE;
         delay_ff <= 3'h0;
         rec_ff   <= 2'h0;
         sar_ff   <= RESULT_RESET;
         bit_ff   <= SAR_FIRST_BIT;
      end else begin
         state_ff <= nxt_state;
         delay_ff <= nxt_delay;
         rec_ff   <= nxt_rec;
         sar_ff   <= nxt_sar;
         bit_ff   <= (state_ff != ST_CONVERT) ? SAR_FIRST_BIT :
                     (tad_tick ? bit_ff - 4'h1 : bit_ff);
      end
   end

   // go flag: hardware set wins over software clear
   always_comb begin
      nxt_go = go_ff;
      if (sw_go_clr) begin
         nxt_go = 1'b0;
      end
      if (complete || abort_sleep) begin
         nxt_go = 1'b0;
      end
      // special event sets go
      // go only rises when a conversion really starts or runs, never stuck while idle
      if (start_req || (trig_strobe && busy && !complete && !abort_sleep)) begin
         nxt_go = 1'b1;
      end
   end

   // done flag: completion wins over write one to clear
   assign nxt_done = complete | (done_ff & ~(wr_en & (addr_ff == OFS_IRQ_STATUS)
                                             & hwdata[DONE_BIT]));

   // power down: sleep abort, or rc sleep completion without interrupt
   always_comb begin
      nxt_pd = pd_ff & sleep_in;
      // divided clock sleep powers converter down, converter_on stays set
      if (sleep_entry && !rc_sel) begin
         nxt_pd = 1'b1;
      end
      // rc sleep done with interrupt disabled
      if (complete && sleep_in && !mask_ff) begin
         nxt_pd = 1'b1;
      end
   end

   // control and status registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_ff     <= 1'b0;
         go_ff     <= 1'b0;
         // clock select back to system over two
         sel_ff    <= SEL_RESET;
         result_ff <= RESULT_RESET;
         done_ff   <= 1'b0;
         mask_ff   <= 1'b0;
         pd_ff     <= 1'b0;
      end else begin
         if (wr_en && addr_ff == OFS_CTRL_ZERO) begin
            on_ff <= hwdata[ON_BIT];
         end
         // three bit field at six to four
         if (wr_en && addr_ff == OFS_CTRL_ONE) begin
            sel_ff <= hwdata[SEL_LSB +: SEL_W];
         end
         if (wr_en && addr_ff == OFS_IRQ_MASK) begin
            mask_ff <= hwdata[DONE_BIT];
         end
         if (complete) begin
            result_ff <= nxt_sar;
         end
         go_ff   <= nxt_go;
         done_ff <= nxt_done;
         pd_ff   <= nxt_pd;
      end
   end

   // event edge registers and timer clear pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_q_ff  <= 1'b0;
         trig_q_ff   <= 1'b0;
         trig_clr_ff <= 1'b0;
      end else begin
         sleep_q_ff  <= sleep_in;
         trig_q_ff   <= special_event_in;
         // timer one counter cleared on the trigger
         trig_clr_ff <= trig_strobe;
      end
   end

   // analog side outputs
   assign sar_trial       = sar_ff;
   assign sample_en       = analog_power & ~busy & (state_ff != ST_RECOVER);
   // converter kept powered in rc clock sleep until a done with interrupt off
   assign analog_power    = on_ff & ~pd_ff;
   assign timer_one_clear = trig_clr_ff;
   // done with interrupt enabled wakes the device
   assign wake_out        = sleep_in & done_ff & mask_ff;
   assign irq             = done_ff & mask_ff;

   // checks
   chk_rc_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      start_req && rc_sel && !abort_sleep |=> state_ff == ST_DELAY ##1 state_ff == ST_DELAY)
      else $error("rc start did not wait");
   chk_done_sets: assert property (@(posedge hclk) disable iff (!hresetn)
      complete |=> done_ff && !go_ff && result_ff == $past(nxt_sar))
      else $error("completion effects missing");
   chk_abort_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      abort_sw |=> state_ff == ST_RECOVER && $stable(result_ff) && rec_ff == RECOVER_TADS)
      else $error("software abort mishandled");
   chk_sleep_abort: assert property (@(posedge hclk) disable iff (!hresetn)
      sleep_entry && !rc_sel |=> pd_ff && !busy && on_ff == $past(on_ff))
      else $error("divided clock sleep not aborted");
   chk_rc_sleep_off: assert property (@(posedge hclk) disable iff (!hresetn)
      complete && sleep_in && !mask_ff |=> pd_ff && on_ff)
      else $error("rc sleep power down missing");
   chk_wake_done: assert property (@(posedge hclk) disable iff (!hresetn)
      complete && sleep_in && mask_ff ##1 sleep_in |-> wake_out)
      else $error("no wake after conversion");
   chk_trig_go: assert property (@(posedge hclk) disable iff (!hresetn)
      trig_strobe && on_ff && !pd_ff && !complete && !(sleep_entry && !rc_sel)
      && state_ff != ST_RECOVER |=> go_ff && timer_one_clear)
      else $error("trigger did not start");
   chk_trig_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      timer_one_clear |=> !timer_one_clear)
      else $error("trigger pulse too long");
   chk_sel_read: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_pend_ff && rd_ready_ff && addr_ff == OFS_CTRL_ONE |->
      hrdata[7] == 1'b0 && hrdata[3:0] == 4'h0 && hrdata[6:4] == sel_ff)
      else $error("clock select readback wrong");
   chk_go_needs_on: assert property (@(posedge hclk) disable iff (!hresetn)
      !on_ff && !go_ff |=> !go_ff)
      else $error("go set while converter off");
   chk_rc_sleep_run: assert property (@(posedge hclk) disable iff (!hresetn)
      sleep_entry && rc_sel && busy && !sw_go_clr |=> busy || done_ff)
      else $error("rc conversion stopped by sleep");

endmodule

// file: bench/ast_analog_model.sv
`timescale 1ns/1ps
// analog front end: hold capacitor plus comparator against the trial word
module ast_analog_model
   import ast_pkg::*;
(
   input  wire logic         hclk,
   input  wire logic [9:0]   sar_trial,
   input  wire logic         sample_en,
   input  wire logic         analog_power,
   input  wire logic [9:0]   level,
   output      logic         cmp_in
);
   logic [9:0] held_ff;        // voltage held on the capacitor
   logic       alt_ff = 1'b0;  // junk pattern while unpowered

   always @(posedge hclk) begin
      if (sample_en) begin
         held_ff <= level;
      end
      alt_ff <= ~alt_ff;
   end

   // keep the trial bit while trial is not above the held level
   assign cmp_in = analog_power ? (sar_trial <= held_ff) : alt_ff;
endmodule

// file: bench/tb_adc_sleep_trigger_control.sv
`timescale 1ns/1ps
module tb_adc_sleep_trigger_control
   import ast_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        sleep_in, special_event_in, rc_clk_in, cmp_in, sample_en;
   logic        analog_power, timer_one_clear, wake_out, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [9:0]  sar_trial, level;
   int          errors, compares, cyc, clr_cnt;

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   ast_adc_ctrl ast_adc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .sleep_in(sleep_in), .special_event_in(special_event_in),
      .rc_clk_in(rc_clk_in), .cmp_in(cmp_in), .sar_trial(sar_trial),
      .sample_en(sample_en), .analog_power(analog_power),
      .timer_one_clear(timer_one_clear), .wake_out(wake_out), .irq(irq));

   ast_analog_model ast_analog_model_i (.hclk(hclk), .sar_trial(sar_trial),
      .sample_en(sample_en), .analog_power(analog_power), .level(level),
      .cmp_in(cmp_in));

   // system clock, 100 ns
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // rc clock, 2.3 us, edges kept away from system clock edges
   initial begin
      rc_clk_in = 1'b0;
      #25;
      forever #1150 rc_clk_in = ~rc_clk_in;
   end

   // hang guard and timer clear pulse counter
   always @(posedge hclk) begin
      cyc++;
      if (timer_one_clear === 1'b1) clr_cnt++;
      if (cyc == 40000) begin
         errors++;
         final_report;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask

   // one single word transfer, waits on ready in both phases
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h00_0000, a};
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : WORD_ZERO;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(1'b0, a, WORD_ZERO, q);
      chk(nm, e, q);
      chk("hresp", WORD_ZERO, 32'(hresp));
   endtask

   // poll until the go flag drops
   task automatic wait_idle;
      int n;
      n = 0;
      do begin bus(1'b0, OFS_CTRL_ZERO, WORD_ZERO, rd); n++; end
      while (rd[GO_BIT] !== 1'b0 && n < 400);
      @(posedge hclk);
   endtask

   // select clock, set level, wait acquisition, then start
   task automatic convert(input logic [2:0] s, input logic [9:0] v);
      level <= v;
      wr(OFS_CTRL_ONE, {25'h000_0000, s, 4'h0});
      repeat (10) @(posedge hclk);
      wr(OFS_CTRL_ZERO, 32'h0000_0003);
   endtask

   task final_report;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      {hresetn, hsel, hwrite, sleep_in, special_event_in} = 5'h00;
      {haddr, hwdata} = 64'h0000_0000_0000_0000;
      htrans = 2'h0;
      hsize = 3'h2;
      level = 10'h000;
      {errors, compares, cyc, clr_cnt} = 128'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // register map and reset values
      rdchk(OFS_CTRL_ONE, WORD_ZERO, "select_reset");
      rdchk(OFS_RESULT, WORD_ZERO, "result_reset");
      wr(OFS_CTRL_ONE, 32'hFFFF_FFFF);
      rdchk(OFS_CTRL_ONE, 32'h0000_0070, "select_bits");
      rdchk(8'h40, WORD_ZERO, "unmapped");
      wr(OFS_CTRL_ZERO, 32'h0000_0003);
      rdchk(OFS_CTRL_ZERO, 32'h0000_0001, "go_with_on");
      $display("test registers done");
      // one conversion for every clock code
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      for (int c = 0; c < 8; c++) begin
         convert(3'(c), 10'(c * 97 + 5));
         wait_idle;
         rdchk(OFS_RESULT, 32'(c * 97 + 5), "result");
         chk("irq_done", 32'h1, 32'(irq));
         wr(OFS_IRQ_STATUS, 32'h0000_0001);
         @(posedge hclk);
         chk("irq_cleared", 32'h0, 32'(irq));
      end
      $display("test clock codes done");
      // software abort keeps the old result
      convert(SEL_DIV64, 10'h3AA);
      repeat (40) @(posedge hclk);
      wr(OFS_CTRL_ZERO, 32'h0000_0001);
      @(posedge hclk);
      chk("abort_recover", 32'h0, 32'(sample_en));
      repeat (300) @(posedge hclk);
      chk("abort_resample", 32'h1, 32'(sample_en));
      rdchk(OFS_RESULT, 32'h0000_02AC, "abort_result");
      rdchk(OFS_IRQ_STATUS, WORD_ZERO, "abort_no_done");
      $display("test abort done");
      // special event trigger starts conversion and clears timer
      wr(OFS_CTRL_ONE, WORD_ZERO);
      level <= 10'h123;
      repeat (10) @(posedge hclk);
      clr_cnt = 0;
      special_event_in <= 1'b1;
      @(posedge hclk);
      special_event_in <= 1'b0;
      wait_idle;
      rdchk(OFS_RESULT, 32'h0000_0123, "trigger_result");
      chk("timer_clear_pulses", 32'h1, 32'(clr_cnt));
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      $display("test trigger done");
      // sleep on a divided clock aborts and powers down
      convert(SEL_DIV64, 10'h055);
      repeat (30) @(posedge hclk);
      sleep_in <= 1'b1;
      repeat (5) @(posedge hclk);
      chk("div_sleep_power", 32'h0, 32'(analog_power));
      bus(1'b0, OFS_CTRL_ZERO, WORD_ZERO, rd);
      chk("div_sleep_on", 32'h1, 32'(rd[ON_BIT]));
      rdchk(OFS_RESULT, 32'h0000_0123, "div_sleep_result");
      rdchk(OFS_STATE, 32'h0000_0001, "div_sleep_state");
      sleep_in <= 1'b0;
      repeat (5) @(posedge hclk);
      chk("wake_power", 32'h1, 32'(analog_power));
      $display("test divided sleep done");
      // rc clock in sleep, interrupt off: finish then power down
      wr(OFS_IRQ_MASK, WORD_ZERO);
      convert(3'h3, 10'h0F0);
      sleep_in <= 1'b1;
      wait_idle;
      rdchk(OFS_RESULT, 32'h0000_00F0, "rc_sleep_result");
      chk("rc_off_power", 32'h0, 32'(analog_power));
      chk("rc_off_wake", 32'h0, 32'(wake_out));
      bus(1'b0, OFS_CTRL_ZERO, WORD_ZERO, rd);
      chk("rc_off_on", 32'h1, 32'(rd[ON_BIT]));
      sleep_in <= 1'b0;
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      // rc clock in sleep, interrupt on: completion wakes
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      convert(3'h7, 10'h30F);
      sleep_in <= 1'b1;
      wait_idle;
      chk("rc_wake", 32'h1, 32'(wake_out));
      rdchk(OFS_RESULT, 32'h0000_030F, "rc_wake_result");
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      @(posedge hclk);
      chk("rc_wake_clear", 32'h0, 32'(wake_out));
      sleep_in <= 1'b0;
      $display("test rc sleep done");
      // reset in mid conversion aborts it and restores the defaults
      convert(SEL_DIV64, 10'h1C3);
      repeat (20) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(OFS_STATE, WORD_ZERO, "reset_idle");
      rdchk(OFS_CTRL_ZERO, WORD_ZERO, "reset_go");
      rdchk(OFS_CTRL_ONE, WORD_ZERO, "reset_select");
      rdchk(OFS_RESULT, WORD_ZERO, "reset_result");
      $display("test reset done");
      final_report;
   end
endmodule
